// File: include/jsr_pkg.sv
package jsr_pkg;
   // ---------------------------------------------
   // register indices (byte address = 4 x index)
   // ---------------------------------------------
   localparam logic [7:0] IDX_PAGE = 8'h66;
   localparam logic [7:0] IDX_INFO = 8'h68;
   localparam logic [7:0] IDX_SENSE = 8'h6A;
   localparam logic [7:0] IDX_CFG = 8'h7A;
   localparam logic [7:0] IDX_PRES = 8'h80;
   localparam logic [7:0] IDX_ISTAT = 8'h81;
   localparam logic [7:0] IDX_IMASK = 8'h82;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int FSEL_LO = 1;
   localparam int INFO_BIT = 4;
   localparam int POLA_BIT = 11;
   localparam int POLB_BIT = 15;
   localparam int LOC_LO = 13;
   localparam int KIND_LO = 8;
   localparam int ORD_LO = 6;
   localparam int VAL_LO = 0;
   localparam int EV_SENSE = 0;
   localparam int EV_PRES = 1;
   // ---------------------------------------------
   // reset values and codes
   // ---------------------------------------------
   localparam logic [4:0] KIND_OUT_INVALID = 5'h00;
   localparam logic [4:0] KIND_OUT_NOCONN = 5'h01;
   localparam logic [4:0] KIND_IN_INVALID = 5'h10;
   localparam logic [4:0] KIND_IN_NOCONN = 5'h11;
   localparam logic [2:0] LOC_POR = 3'h0;
   localparam logic [1:0] ORD_RST = 2'h0;
   localparam logic [5:0] VAL_RST = 6'h00;
   localparam logic [3:0] FC_IN_LO = 4'h4;
   localparam logic [3:0] FC_IN_HI = 4'hA;
   localparam int NFUNC_DEF = 13;
   // ---------------------------------------------
   // sense circuitry result
   // ---------------------------------------------
   typedef struct packed {
      logic done;
      logic [3:0] fc;
      logic is_in;
      logic [4:0] kind;
      logic [1:0] order;
      logic [5:0] value;
   } jsr_sense_s;
endpackage : jsr_pkg

// File: logic/jsr_top.sv
// Notes on behaviour
// - one sense register copy per function code below NFUNC (0..12 by default), chosen by page bits 4..1.
// - jack location cleared only by power-on reset, kept over other resets.
// - other sense fields hold the latest sense operation outcome.
// - six-bit read-only result value, scaled by the order field.
// - order field 00 x1, 01 x10, 10 x100, 11 x1000 ohms.
// - output sense type codes 0x00..0x0F, default no connection 0x01.
// - input sense type codes 0x10..0x1F, default no connection 0x11.
// - type code read-only; meaning depends on input or output connection.
// - three-bit jack location is read/write firmware storage.
// - both sense groups power up as normally-open.
// - group A polarity is config bit 11.
// - group B polarity is config bit 15.
// - polarity bit one means normally-closed switches.
// - groups set independently; jacks of one group share a setting.
// - up to four jacks per sense line, told apart by resistance.
// - line A to bits 7,4,5,1; line B to bits 0,3,2,6.
// - info valid cleared by writing one, set when a sense cycle completes.
//
// Our own choice: register access over Wishbone.
module jsr_top
   import jsr_pkg::*;
#(
   parameter int NFUNC = NFUNC_DEF
) (
   // clock, resets, enable
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_por,
   input wire logic i_ce,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [9:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // sense circuitry
   input wire jsr_sense_s i_sense,
   input wire logic [3:0] i_ladder_a,
   input wire logic [3:0] i_ladder_b,
   output logic [7:0] o_presence,
   // interrupt
   output logic o_irq
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic [3:0] fsel_q;
   logic pol_a_q;
   logic pol_b_q;
   logic [2:0] loc_q [NFUNC];
   logic [4:0] kind_q [NFUNC];
   logic [1:0] ord_q [NFUNC];
   logic [5:0] val_q [NFUNC];
   logic [NFUNC-1:0] info_q;
   logic [7:0] pres_q;
   logic [1:0] istat_q;
   logic [1:0] imask_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic irq_q;

   logic rst_any;
   logic acc;
   logic wr;
   logic [15:0] wmask;
   logic [15:0] wdat;
   logic sel_ok;
   logic [3:0] fs_idx;
   logic sns_ok;
   logic [3:0] sns_idx;
   logic [7:0] idx;
   logic [3:0] pa;
   logic [3:0] pb;
   logic [7:0] pres_d;
   logic [1:0] ev;
   logic [15:0] rd_d;

   assign rst_any = i_rst | i_por;
   assign idx = i_wb_adr[9:2];
   assign acc = i_wb_cyc & i_wb_stb & ~ack_q;
   assign wr = acc & i_wb_we;
   assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   assign wdat = i_wb_dat[15:0] & wmask;

   assign sel_ok = int'(fsel_q) < NFUNC;
   assign fs_idx = sel_ok ? fsel_q : 4'h0;
   assign sns_ok = i_sense.done & (int'(i_sense.fc) < NFUNC);
   assign sns_idx = sns_ok ? i_sense.fc : 4'h0;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [4:0] jsr_fix_kind(input logic is_in, input logic [4:0] k);
      logic [4:0] r;
      r = k;
      if (!is_in && k[4]) begin
         r = KIND_OUT_INVALID;
      end
      if (is_in && !k[4]) begin
         r = KIND_IN_INVALID;
      end
      return r;
   endfunction : jsr_fix_kind

   function automatic logic [4:0] jsr_kind_rst(input int f);
      logic [3:0] c;
      c = f[3:0];
      if (c >= FC_IN_LO && c <= FC_IN_HI) begin
         return KIND_IN_NOCONN;
      end
      return KIND_OUT_NOCONN;
   endfunction : jsr_kind_rst

   // ---------------------------------------------
   // page and configuration
   // ---------------------------------------------
   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         fsel_q <= 4'h0;
      end else if (i_ce && wr && idx == IDX_PAGE && i_wb_sel[0]) begin
         fsel_q <= i_wb_dat[FSEL_LO+:4];
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         pol_a_q <= 1'b0;
         pol_b_q <= 1'b0;
      end else if (i_ce && wr && idx == IDX_CFG && i_wb_sel[1]) begin
         pol_a_q <= i_wb_dat[POLA_BIT];
         pol_b_q <= i_wb_dat[POLB_BIT];
      end
   end

   // ---------------------------------------------
   // jack location, power-on only
   // ---------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_por) begin
         for (int f = 0; f < NFUNC; f++) begin
            loc_q[f] <= LOC_POR;
         end
      end else if (i_ce && wr && idx == IDX_SENSE && sel_ok && i_wb_sel[1]) begin
         loc_q[fs_idx] <= i_wb_dat[LOC_LO+:3];
      end
   end

   // ---------------------------------------------
   // sense results
   // ---------------------------------------------
   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         for (int f = 0; f < NFUNC; f++) begin
            kind_q[f] <= jsr_kind_rst(f);
            ord_q[f] <= ORD_RST;
            val_q[f] <= VAL_RST;
         end
      end else if (i_ce && sns_ok) begin
         kind_q[sns_idx] <= jsr_fix_kind(i_sense.is_in, i_sense.kind);
         ord_q[sns_idx] <= i_sense.order;
         val_q[sns_idx] <= i_sense.value;
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         info_q <= '0;
      end else if (i_ce) begin
         for (int f = 0; f < NFUNC; f++) begin
            if (sns_ok && int'(sns_idx) == f) begin
               info_q[f] <= 1'b1;
            end else if (wr && idx == IDX_INFO && fs_idx == f[3:0] && sel_ok && wdat[INFO_BIT]) begin
               info_q[f] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------
   // jack presence
   // ---------------------------------------------
   always_comb begin
      pa = i_ladder_a ^ {4{pol_a_q}};
      pb = i_ladder_b ^ {4{pol_b_q}};
      pres_d = {pa[0], pb[3], pa[2], pa[1], pb[1], pb[2], pa[3], pb[0]};
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         pres_q <= 8'h00;
      end else if (i_ce) begin
         pres_q <= pres_d;
      end
   end

   assign o_presence = pres_q;

   // ---------------------------------------------
   // interrupts
   // ---------------------------------------------
   assign ev = {pres_d != pres_q, sns_ok};

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         istat_q <= 2'h0;
      end else if (i_ce) begin
         if (wr && idx == IDX_ISTAT) begin
            istat_q <= (istat_q & ~wdat[1:0]) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         imask_q <= 2'h0;
      end else if (i_ce && wr && idx == IDX_IMASK && i_wb_sel[0]) begin
         imask_q <= i_wb_dat[1:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         irq_q <= 1'b0;
      end else if (i_ce) begin
         irq_q <= |(istat_q & imask_q);
      end
   end

   assign o_irq = irq_q;

   // ---------------------------------------------
   // bus read and acknowledge
   // ---------------------------------------------
   always_comb begin
      rd_d = 16'h0000;
      case (idx)
         IDX_PAGE: begin
            rd_d[FSEL_LO+:4] = fsel_q;
         end
         IDX_INFO: begin
            rd_d[INFO_BIT] = sel_ok & info_q[fs_idx];
         end
         IDX_SENSE: begin
            if (sel_ok) begin
               rd_d = {loc_q[fs_idx], kind_q[fs_idx], ord_q[fs_idx], val_q[fs_idx]};
            end
         end
         IDX_CFG: begin
            rd_d[POLA_BIT] = pol_a_q;
            rd_d[POLB_BIT] = pol_b_q;
         end
         IDX_PRES: begin
            rd_d[7:0] = pres_q;
         end
         IDX_ISTAT: begin
            rd_d[1:0] = istat_q;
         end
         IDX_IMASK: begin
            rd_d[1:0] = imask_q;
         end
         default: begin
            rd_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (rst_any) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else if (i_ce) begin
         ack_q <= acc;
         if (acc && !i_wb_we) begin
            dat_q <= {16'h0000, rd_d};
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   AST_LOC_WRITE: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && wr && idx == IDX_SENSE && sel_ok && i_wb_sel[1]
      |=> loc_q[$past(fs_idx)] == $past(i_wb_dat[15:13]))
      else $error("jack location not stored");

   AST_LOC_KEEP: assert property (@(posedge i_clock) disable iff (i_por)
      i_rst |=> loc_q[0] == $past(loc_q[0]))
      else $error("jack location lost on reset");

   AST_SENSE_STORE: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && sns_ok |=> val_q[$past(sns_idx)] == $past(i_sense.value)
      && ord_q[$past(sns_idx)] == $past(i_sense.order))
      else $error("sense result not stored");

   AST_OUT_CLASS: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && sns_ok && !i_sense.is_in && i_sense.kind[4]
      |=> kind_q[$past(sns_idx)] == KIND_OUT_INVALID)
      else $error("output type code out of class");

   AST_IN_CLASS: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && sns_ok && i_sense.is_in && !i_sense.kind[4]
      |=> kind_q[$past(sns_idx)] == KIND_IN_INVALID)
      else $error("input type code out of class");

   AST_RO_KEEP: assert property (@(posedge i_clock) disable iff (rst_any)
      wr && idx == IDX_SENSE && !sns_ok
      |=> kind_q[$past(fs_idx)] == $past(kind_q[fs_idx]) && val_q[$past(fs_idx)] == $past(val_q[fs_idx]))
      else $error("write disturbed sense result");

   AST_POL_POR: assert property (@(posedge i_clock)
      i_por |=> !pol_a_q && !pol_b_q)
      else $error("polarity not normally-open after power-on");

   AST_POL_A: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && wr && idx == IDX_CFG && i_wb_sel[1]
      |=> pol_a_q == $past(i_wb_dat[11]) && pol_b_q == $past(i_wb_dat[15]))
      else $error("polarity bits not stored");

   AST_PRES_MAP: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce |=> o_presence[7] == ($past(i_ladder_a[0]) ^ $past(pol_a_q))
      && o_presence[6] == ($past(i_ladder_b[3]) ^ $past(pol_b_q)))
      else $error("presence map wrong");

   AST_INFO_SET: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && sns_ok |=> info_q[$past(sns_idx)] ##1 (!i_ce || info_q[$past(sns_idx, 2)] || wr || $past(wr)))
      else $error("info valid not set by sense");

   AST_ACK_DROP: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && o_wb_ack |=> !o_wb_ack)
      else $error("ack held over two cycles");

   AST_INFO_CLEAR: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && wr && idx == IDX_INFO && sel_ok && wdat[INFO_BIT] && !(sns_ok && sns_idx == fs_idx)
      |=> !info_q[$past(fs_idx)])
      else $error("info valid not cleared by writing one");

   AST_SENSE_EVENT: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && sns_ok |=> istat_q[EV_SENSE])
      else $error("sense done not flagged");

   AST_PRES_EVENT: assert property (@(posedge i_clock) disable iff (rst_any)
      i_ce && pres_d != pres_q |=> istat_q[EV_PRES])
      else $error("presence change not flagged");

   AST_CE_FREEZE: assert property (@(posedge i_clock) disable iff (rst_any)
      !i_ce |=> $stable(pres_q) && $stable(istat_q) && $stable(fsel_q) && $stable(o_wb_ack))
      else $error("state moved while clock enable low");

endmodule : jsr_top

// File: verif/jsr_jacks.sv
module jsr_jacks
   import jsr_pkg::*;
(
   // clock and sense trigger
   input wire logic i_clock,
   input wire logic i_fire,
   input wire jsr_sense_s i_res,
   // jack wiring
   input wire logic [3:0] i_plug_a,
   input wire logic [3:0] i_plug_b,
   input wire logic i_nc_a,
   input wire logic i_nc_b,
   // lines to the block
   output jsr_sense_s o_sense,
   output logic [3:0] o_ladder_a,
   output logic [3:0] o_ladder_b
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge i_clock) begin
      o_sense <= i_fire ? {1'b1, i_res[17:0]} : {1'b0, ~i_res[17:0]};
   end
   always_ff @(posedge i_clock) begin
      o_ladder_a <= i_plug_a ^ {4{i_nc_a}};
      o_ladder_b <= i_plug_b ^ {4{i_nc_b}};
   end
endmodule : jsr_jacks

// File: verif/jsr_top_tb.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
$display("[FAIL] %0t: got %h want %h", $time, g, e); end end
module jsr_top_tb
   import jsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock, i_rst, i_por, ce, cyc, stb, we, fire, nca, ncb, ack, irq;
   logic [9:0] adr;
   logic [31:0] wdat, rdat;
   logic [3:0] sel, pa, pb, la, lb;
   logic [7:0] pres;
   logic [5:0] v;
   jsr_sense_s res, sense;
   logic [15:0] eq[$], mq[$], sx[16];
   logic [4:0] kinds[14];
   int fail_count, comparisons, seed, fc;
   jsr_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_por(i_por), .i_ce(ce), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack),
      .o_wb_dat(rdat), .i_sense(sense), .i_ladder_a(la), .i_ladder_b(lb), .o_presence(pres), .o_irq(irq));
   jsr_jacks jacks (.i_clock(i_clock), .i_fire(fire), .i_res(res), .i_plug_a(pa), .i_plug_b(pb),
      .i_nc_a(nca), .i_nc_b(ncb), .o_sense(sense), .o_ladder_a(la), .o_ladder_b(lb));
   // ---------------------------------------------
   // bus, sense and report tasks
   // ---------------------------------------------
   task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [15:0] m);
      if (!w) begin
         eq.push_back(d & m);
         mq.push_back(m);
      end
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      sel <= 4'h3;
      @(posedge i_clock);
      while (ack !== 1'b1) @(posedge i_clock);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge i_clock);
   endtask : bus
   task automatic fire_sense(input logic [3:0] f, input logic i, input logic [4:0] k, input logic [1:0] o);
      res <= '{done: 1'b0, fc: f, is_in: i, kind: k, order: o, value: v};
      fire <= 1'b1;
      @(posedge i_clock);
      fire <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask : fire_sense
   task automatic pulse(input logic p);
      if (p) i_por <= 1'b1;
      else i_rst <= 1'b1;
      @(posedge i_clock);
      i_por <= 1'b0;
      i_rst <= 1'b0;
      @(posedge i_clock);
   endtask : pulse
   task automatic wrap_up();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   function automatic logic [7:0] pmap(input logic [3:0] a, input logic [3:0] b);
      return {a[0], b[3], a[2], a[1], b[1], b[2], a[3], b[0]};
   endfunction : pmap
   // ---------------------------------------------
   // clock, monitor, watchdog
   // ---------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && eq.size() > 0) begin
         `CHK(rdat[15:0] & mq[0], eq[0])
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      fail_count++;
      wrap_up();
   end
   // ---------------------------------------------
   // test sequence
   // ---------------------------------------------
   initial begin
      seed = 32'h9AFA8F3C;
      {i_rst, i_por} = 2'b11;
      {cyc, stb, we, fire, nca, ncb} = 6'h00;
      ce = 1'b1;
      {adr, wdat, sel, pa, pb, v} = '0;
      res = '0;
      kinds = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h0A, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h19, 5'h1A, 5'h1F};
      repeat (8) @(posedge i_clock);
      {i_rst, i_por} <= 2'b00;
      @(posedge i_clock);
      bus(0, IDX_CFG, 16'h0000, 16'hFFFF);
      bus(0, IDX_SENSE, 16'h0100, 16'hFFFF);
      bus(1, IDX_PAGE, 16'h0008, 16'h0000);
      bus(0, IDX_SENSE, 16'h1100, 16'hFFFF);
      bus(0, 8'h10, 16'h0000, 16'hFFFF);
      $display("reset values test done");
      for (int i = 0; i < 8; i++) begin
         pa <= 4'($random(seed));
         pb <= 4'($random(seed));
         nca <= 1'($random(seed));
         ncb <= 1'($random(seed));
         bus(1, IDX_CFG, {i[1], 3'h0, i[0], 11'h000}, 16'h0000);
         repeat (3) @(posedge i_clock);
         `CHK(pres, pmap(pa ^ {4{nca ^ i[0]}}, pb ^ {4{ncb ^ i[1]}}))
         bus(0, IDX_PRES, {8'h00, pmap(pa ^ {4{nca ^ i[0]}}, pb ^ {4{ncb ^ i[1]}})}, 16'h00FF);
      end
      ce <= 1'b0;
      pa <= ~pa;
      repeat (4) @(posedge i_clock);
      `CHK(pres, pmap(~pa ^ {4{nca ^ 1'b1}}, pb ^ {4{ncb ^ 1'b1}}))
      ce <= 1'b1;
      repeat (3) @(posedge i_clock);
      `CHK(pres, pmap(pa ^ {4{nca ^ 1'b1}}, pb ^ {4{ncb ^ 1'b1}}))
      bus(1, IDX_IMASK, 16'h0002, 16'h0000);
      `CHK(irq, 1'b1)
      bus(0, IDX_ISTAT, 16'h0002, 16'h0002);
      $display("presence test done");
      bus(1, IDX_ISTAT, 16'h0003, 16'h0000);
      for (int j = 0; j < 14; j++) begin
         fc = j < 4 ? j : (j < 7 ? 11 + j % 2 : j - 3);
         v = 6'($random(seed));
         sx[fc] = {3'h0, kinds[j], 2'(j), v};
         bus(1, IDX_IMASK, 16'(j % 2), 16'h0000);
         fire_sense(4'(fc), j > 6, kinds[j], 2'(j));
         `CHK(irq, 1'(j % 2))
         bus(1, IDX_PAGE, 16'(fc << 1), 16'h0000);
         bus(0, IDX_SENSE, sx[fc], 16'hFFFF);
         bus(0, IDX_INFO, 16'h0010, 16'h0010);
         bus(1, IDX_INFO, 16'h0000, 16'h0000);
         bus(0, IDX_INFO, 16'h0010, 16'h0010);
         bus(1, IDX_INFO, 16'h0010, 16'h0000);
         bus(0, IDX_INFO, 16'h0000, 16'h0010);
         bus(0, IDX_ISTAT, 16'h0001, 16'h0001);
         bus(1, IDX_ISTAT, 16'h0003, 16'h0000);
         @(posedge i_clock);
         `CHK(irq, 1'b0)
      end
      for (int f = 0; f < 13; f++) begin
         bus(1, IDX_PAGE, 16'(f << 1), 16'h0000);
         bus(0, IDX_SENSE, sx[f], 16'hFFFF);
      end
      v = 6'($random(seed));
      fire_sense(4'h0, 1'b0, 5'h15, 2'h3);
      fire_sense(4'h5, 1'b1, 5'h03, 2'h1);
      fire_sense(4'hD, 1'b0, 5'h02, 2'h2);
      bus(1, IDX_PAGE, 16'h0000, 16'h0000);
      bus(0, IDX_SENSE, {3'h0, 5'h00, 2'h3, v}, 16'hFFFF);
      bus(1, IDX_PAGE, 16'h000A, 16'h0000);
      bus(0, IDX_SENSE, {3'h0, 5'h10, 2'h1, v}, 16'hFFFF);
      bus(1, IDX_PAGE, 16'h001A, 16'h0000);
      bus(0, IDX_SENSE, 16'h0000, 16'hFFFF);
      $display("sense test done");
      bus(1, IDX_PAGE, 16'h0008, 16'h0000);
      bus(1, IDX_SENSE, 16'hFFFF, 16'h0000);
      bus(0, IDX_SENSE, {3'h7, sx[4][12:0]}, 16'hFFFF);
      pulse(1'b0);
      bus(1, IDX_PAGE, 16'h0008, 16'h0000);
      bus(0, IDX_SENSE, 16'hF100, 16'hFFFF);
      pulse(1'b1);
      bus(1, IDX_PAGE, 16'h0008, 16'h0000);
      bus(0, IDX_SENSE, 16'h1100, 16'hFFFF);
      $display("location test done");
      wrap_up();
   end
endmodule : jsr_top_tb
